// File: logic/swdt_pkg.sv
`default_nettype none
package swdt_pkg;
	localparam int CLK_PERIOD_NS = 40;
	localparam int NS_PER_S      = 1000000000;
	localparam int MS_PER_S      = 1000;
	localparam int OSC_FREQ_HZ   = 10240;
	localparam int TICK_DIV      = NS_PER_S / CLK_PERIOD_NS / OSC_FREQ_HZ;
	localparam int DIV_W         = 12;
	localparam int CNT_W         = 15;

	localparam int INT_SHORT_MS = 100;
	localparam int INT_LONG_MS  = 1600;
	localparam int INT_RST_MS   = 200;
	localparam logic [CNT_W-1:0] INT_SHORT =
		CNT_W'(INT_SHORT_MS * OSC_FREQ_HZ / MS_PER_S);
	localparam logic [CNT_W-1:0] INT_LONG  =
		CNT_W'(INT_LONG_MS * OSC_FREQ_HZ / MS_PER_S);
	localparam logic [CNT_W-1:0] INT_RST   =
		CNT_W'(INT_RST_MS * OSC_FREQ_HZ / MS_PER_S);
	localparam logic [CNT_W-1:0] EXT_SHORT = 15'h0400;
	localparam logic [CNT_W-1:0] EXT_LONG  = 15'h1000;
	localparam logic [CNT_W-1:0] EXT_RST   = 15'h0800;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK   = 8'h08;
	localparam logic [7:0] REG_STATE  = 8'h0c;
	localparam int CTRL_EN_BIT    = 0;
	localparam logic CTRL_EN_RST  = 1'b1;
	localparam int EV_W           = 3;
	localparam int EV_EXPIRE      = 0;
	localparam int EV_RST_END     = 1;
	localparam int EV_FIRST_KICK  = 2;
	localparam int STATE_RSTN_BIT = 4;
	localparam int STATE_WDO_BIT  = 5;
	localparam int STATE_CNT_LSB  = 16;
	localparam int HTRANS_ACT_BIT = 1;

	typedef enum logic [3:0] {
		S_LONG  = 4'b0001,
		S_SHORT = 4'b0010,
		S_RST   = 4'b0100,
		S_OFF   = 4'b1000
	} swdt_state_e;

	typedef struct packed {
		logic kick;
		logic kick_float;
		logic sel;
		logic sel_float;
		logic tb_in;
		logic tb_float;
		logic pfail;
		logic batt;
	} swdt_pins_s;

	typedef struct packed {
		logic [CNT_W-1:0] short_lim;
		logic [CNT_W-1:0] long_lim;
		logic [CNT_W-1:0] rst_lim;
	} swdt_lim_s;

	// Period limits in timebase ticks for the selected configuration.
	function automatic swdt_lim_s swdt_limits(input logic ext,
		input logic tb_high, input logic fixed);
		swdt_lim_s l;
		l.long_lim  = ext ? EXT_LONG : INT_LONG;
		l.rst_lim   = ext ? EXT_RST : INT_RST;
		l.short_lim = ext ? EXT_SHORT : (tb_high ? INT_LONG : INT_SHORT);
		if (fixed) begin
			l.short_lim = INT_LONG;
		end
		return l;
	endfunction : swdt_limits
endpackage : swdt_pkg
`default_nettype wire

// File: logic/swdt_top.sv
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module swdt_top #(
	parameter int   TICK_DIV_P = swdt_pkg::TICK_DIV,
	parameter logic FIXED      = 1'b0
) (
	input  wire logic               clk_i,               // 25 MHz clock.
	input  wire logic               rst_b_i,             // Async reset.
	input  wire swdt_pkg::swdt_pins_s pins_i,            // Raw pins.
	input  wire logic               hsel_i,              // Slave select.
	input  wire logic [31:0]        haddr_i,             // Address.
	input  wire logic [1:0]         htrans_i,            // Transfer type.
	input  wire logic               hwrite_i,            // Write flag.
	input  wire logic [2:0]         hsize_i,             // Size.
	input  wire logic [31:0]        hwdata_i,            // Write data.
	input  wire logic               hready_i,            // Bus ready.
	output var  logic [31:0]        hrdata_o,            // Read data.
	output var  logic               hreadyout_o,         // Slave ready.
	output var  logic               hresp_o,             // Response.
	output var  logic               reset_n_o,           // System reset.
	output var  logic               watchdog_expired_n_o, // Expired.
	output var  logic               irq_o                // Interrupt.
);
	import swdt_pkg::*;

	////////////////////////////////////////////////////////////////////
	swdt_pins_s       s1;
	swdt_pins_s       s2;
	swdt_pins_s       s3;
	swdt_pins_s       fin;
	logic [DIV_W-1:0] div_cnt;
	logic             div_done;
	logic             tb_prev;
	logic             tb_rise;
	logic             kick_prev;
	logic             ext_mode;
	logic             tick;
	logic             kick_edge;
	logic             off;
	logic             counting;
	logic             expire;
	logic             rst_done;
	logic             first_kick;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] cnt;
	swdt_lim_s        lim;
	swdt_state_e      state;
	logic             ctrl_en;
	logic [EV_W-1:0]  status;
	logic [EV_W-1:0]  mask;
	logic [EV_W-1:0]  events;
	logic             wr_pend;
	logic [7:0]       wr_addr;
	logic [31:0]      next_rdata;
	logic             addr_phase;

	////////////////////////////////////////////////////////////////////
	// Each pin bit changes only once two later stages agree.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s1  <= '0;
			s2  <= '0;
			s3  <= '0;
			fin <= '0;
		end else begin
			s1 <= pins_i;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < $bits(swdt_pins_s); i++) begin
				if (s2[i] == s3[i]) begin
					fin[i] <= s3[i];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Internal oscillator stand-in: one tick per TICK_DIV_P cycles.
	assign div_done = (div_cnt == DIV_W'(TICK_DIV_P - 1));

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div_cnt <= '0;
		end else if (div_done) begin
			div_cnt <= '0;
		end else begin
			div_cnt <= div_cnt + DIV_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tb_prev <= 1'b0;
		end else begin
			tb_prev <= fin.tb_in;
		end
	end

	assign tb_rise  = fin.tb_in & ~tb_prev;
	assign ext_mode = ~FIXED & ~(fin.sel | fin.sel_float);
	assign tick     = ext_mode ? tb_rise : div_done;
	assign lim      = swdt_limits(ext_mode, fin.tb_in | fin.tb_float,
		FIXED);

	////////////////////////////////////////////////////////////////////
	// Kick level is sampled per tick so edges are seen at tick rate.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			kick_prev <= 1'b0;
		end else if (tick || off) begin
			kick_prev <= fin.kick;
		end
	end

	assign off = fin.pfail | fin.batt | fin.kick_float |
		~ctrl_en;
	assign kick_edge  = tick & ~off & (fin.kick != kick_prev);
	assign counting   = (state == S_LONG) || (state == S_SHORT);
	assign period     = (state == S_LONG) ? lim.long_lim : lim.short_lim;
	assign expire     = tick & ~off & counting & ~kick_edge &
		(cnt >= period - CNT_W'(1));
	assign rst_done   = tick & ~off & (state == S_RST) &
		(cnt >= lim.rst_lim - CNT_W'(1));
	assign first_kick = kick_edge & (state == S_LONG);

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= S_LONG;
			cnt   <= '0;
		end else if (off) begin
			state <= S_OFF;
			cnt   <= '0;
		end else begin
			case (state)
				S_OFF: begin
					state <= S_LONG;
					cnt   <= '0;
				end
				S_LONG, S_SHORT: begin
					if (kick_edge) begin
						state <= S_SHORT;
						cnt   <= '0;
					end else if (expire) begin
						state <= S_RST;
						cnt   <= '0;
					end else if (tick) begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				S_RST: begin
					if (rst_done) begin
						state <= S_LONG;
						cnt   <= '0;
					end else if (tick) begin
						cnt <= cnt + CNT_W'(1);
					end
				end
				default: begin
					state <= S_LONG;
					cnt   <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			reset_n_o <= 1'b1;
		end else begin
			reset_n_o <= (state != S_RST);
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			watchdog_expired_n_o <= 1'b1;
		end else if (fin.pfail || fin.batt) begin
			watchdog_expired_n_o <= 1'b1;
		end else if (expire) begin
			watchdog_expired_n_o <= 1'b0;
		end else if (kick_edge) begin
			watchdog_expired_n_o <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus slave: zero wait states, always OKAY.
	assign addr_phase = hsel_i & htrans_i[HTRANS_ACT_BIT] & hready_i;
	assign events     = {first_kick, rst_done, expire};

	always_comb begin
		next_rdata = '0;
		case (haddr_i[7:0])
			REG_CTRL:   next_rdata[CTRL_EN_BIT] = ctrl_en;
			REG_STATUS: next_rdata[EV_W-1:0] = status;
			REG_MASK:   next_rdata[EV_W-1:0] = mask;
			REG_STATE: begin
				next_rdata[$bits(swdt_state_e)-1:0] = state;
				next_rdata[STATE_RSTN_BIT] = reset_n_o;
				next_rdata[STATE_WDO_BIT] = watchdog_expired_n_o;
				next_rdata[STATE_CNT_LSB +: CNT_W] = cnt;
			end
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			wr_pend <= 1'b0;
			wr_addr <= '0;
		end else if (hready_i) begin
			wr_pend <= addr_phase & hwrite_i;
			wr_addr <= haddr_i[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			hrdata_o    <= '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end else begin
			hrdata_o    <= (addr_phase && !hwrite_i) ? next_rdata : '0;
			hreadyout_o <= 1'b1;
			hresp_o     <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ctrl_en <= CTRL_EN_RST;
			mask    <= '0;
		end else if (wr_pend) begin
			if (wr_addr == REG_CTRL) begin
				ctrl_en <= hwdata_i[CTRL_EN_BIT];
			end
			if (wr_addr == REG_MASK) begin
				mask <= hwdata_i[EV_W-1:0];
			end
		end
	end

	// A new event wins over a clear in the same cycle.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			status <= '0;
		end else if (wr_pend && wr_addr == REG_STATUS) begin
			status <= (status & ~hwdata_i[EV_W-1:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(status & mask);
		end
	end

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence enter_rst_s;
		state == S_RST ##1 !reset_n_o;
	endsequence

	a_expire_resets: assert property (
		expire |=> enter_rst_s)
		else $error("Expiry did not drive reset low.");
	a_rst_restart: assert property (
		rst_done |=> state == S_LONG && cnt == '0 ##1 reset_n_o)
		else $error("Count did not restart after reset.");
	a_first_short: assert property (
		first_kick |=> state == S_SHORT && cnt == '0)
		else $error("First kick did not select short period.");
	a_kick_clears: assert property (
		(kick_edge && state == S_SHORT) |=> cnt == '0)
		else $error("Kick edge did not clear the count.");
	a_float_off: assert property (
		fin.kick_float |=> state == S_OFF && !expire)
		else $error("Floating kick left watchdog running.");
	a_supply_off: assert property (
		(fin.pfail || fin.batt) |=> state == S_OFF ##1
		watchdog_expired_n_o)
		else $error("Low supply did not disable the watchdog.");
	a_wdo_cycle: assert property (
		(expire && !fin.pfail && !fin.batt) |=> !watchdog_expired_n_o)
		else $error("Expiry did not drop the expired flag.");
	a_wdo_release: assert property (
		(kick_edge && !expire) |=> watchdog_expired_n_o)
		else $error("Kick edge did not raise the expired flag.");
	a_ext_counts: assert property (
		(ext_mode && tick && !off && !kick_edge && state == S_SHORT &&
		cnt == EXT_SHORT - CNT_W'(1)) |=> state == S_RST)
		else $error("External short period count is wrong.");
	a_int_short: assert property (
		(!ext_mode && !FIXED && !fin.tb_in && !fin.tb_float && tick &&
		!off && !kick_edge && state == S_SHORT &&
		cnt == INT_SHORT - CNT_W'(1)) |=> state == S_RST)
		else $error("Internal short period count is wrong.");
	a_int_reset: assert property (
		(!ext_mode && rst_done) |-> cnt == INT_RST - CNT_W'(1))
		else $error("Internal reset active time is wrong.");
	a_fixed_short: assert property (
		(FIXED && tick && !off && !kick_edge && state == S_SHORT &&
		cnt == INT_SHORT - CNT_W'(1)) |=> state == S_SHORT)
		else $error("Fixed variant used the short period.");
	a_wdo_supply: assert property (
		(fin.pfail || fin.batt) |=> watchdog_expired_n_o)
		else $error("Low supply did not raise the expired flag.");
	a_batt_ignore: assert property (
		fin.batt |-> !kick_edge && !expire)
		else $error("Kick input was used in backup mode.");
endmodule : swdt_top
`default_nettype wire

// File: tb/swdt_bench.sv
`timescale 1ns/1ps
`default_nettype none
module swdt_bench;
	import swdt_pkg::*;
	localparam int TP   = 4;
	localparam int CEIL = 90000;
	logic        clk_i   = 1'b0;
	logic        rst_b_i = 1'b0;
	logic        kick_req = 1'b0;
	logic        ext   = 1'b0;
	logic        kfl   = 1'b0;
	logic        sel   = 1'b1;
	logic        pfail = 1'b0;
	logic        batt  = 1'b0;
	logic        sfl   = 1'b0;
	logic        tfl   = 1'b0;
	logic        hsel  = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr  = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic        kick;
	logic        tb_in;
	logic [31:0] hrdata;
	logic        hready;
	logic        rst_n;
	logic        wdo_n;
	logic        irq;
	logic        hresp;
	logic        fx_ready;
	logic        fx_rst_n;
	logic [31:0] rd;
	swdt_pins_s  pins;
	int          mismatches = 0;
	int          comparisons = 0;
	int          cycles = 0;
	int          n;

	assign pins = '{kick, kfl, sel, sfl, tb_in, tfl, pfail, batt};

	swdt_top #(.TICK_DIV_P(TP)) u_dut (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins), .hsel_i(hsel),
		.haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
		.hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.reset_n_o(rst_n), .watchdog_expired_n_o(wdo_n), .irq_o(irq)
	);

	// Variant without select pins; its bus stays idle.
	swdt_top #(.TICK_DIV_P(TP), .FIXED(1'b1)) u_fixed (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .pins_i(pins), .hsel_i(1'b0),
		.haddr_i(32'h0), .htrans_i(2'h0), .hwrite_i(1'b0),
		.hsize_i(3'h2), .hwdata_i(32'h0), .hready_i(fx_ready),
		.hrdata_o(), .hreadyout_o(fx_ready), .hresp_o(),
		.reset_n_o(fx_rst_n), .watchdog_expired_n_o(), .irq_o()
	);

	swdt_host u_host (
		.clk_i(clk_i), .rst_b_i(rst_b_i), .kick_i(kick_req), .ext_i(ext),
		.kick_o(kick), .tb_in_o(tb_in)
	);

	always #20 clk_i = ~clk_i;

	always @(posedge clk_i) begin
		cycles++;
		if (cycles >= CEIL) begin
			mismatches++;
			conclude();
		end
	end

	task conclude;
		$display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : conclude

	task chk(string nm, logic [31:0] e, logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task rng(string nm, int lo, int hi, int g);
		comparisons++;
		if (g < lo || g > hi) begin
			mismatches++;
			$display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask : rng

	// One single transfer; read data is taken at the edge ending the data phase.
	task xfer(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] m,
		logic [31:0] e);
		@(posedge clk_i);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {24'h0, a};
		@(posedge clk_i);
		while (hready !== 1'b1) @(posedge clk_i);
		htrans <= 2'h0;
		hsel   <= 1'b0;
		hwdata <= d;
		@(posedge clk_i);
		while (hready !== 1'b1) @(posedge clk_i);
		chk("hresp", 32'h0, {31'h0, hresp});
		rd = hrdata;
		if (!w) chk("hrdata", e, hrdata & m);
	endtask : xfer

	task kick_it;
		@(posedge clk_i);
		kick_req <= 1'b1;
		@(posedge clk_i);
		kick_req <= 1'b0;
	endtask : kick_it

	task cnt(logic lvl, int mx);
		n = 0;
		while (rst_n !== lvl && n < mx) begin
			@(posedge clk_i);
			n++;
		end
	endtask : cnt

	initial begin
		repeat (6) @(posedge clk_i);
		rst_b_i <= 1'b1;
		xfer(1'b0, REG_CTRL, 32'h0, 32'hffffffff, 32'h1);
		xfer(1'b0, REG_MASK, 32'h0, 32'hffffffff, 32'h0);
		xfer(1'b0, 8'h10, 32'h0, 32'hffffffff, 32'h0);
		xfer(1'b0, REG_STATE, 32'h0, 32'h3f, 32'h31);
		xfer(1'b1, REG_MASK, 32'h7, 32'h0, 32'h0);
		kick_it;
		repeat (12) @(posedge clk_i);
		xfer(1'b0, REG_STATE, 32'h0, 32'h3f, 32'h32);
		xfer(1'b0, REG_STATUS, 32'h0, 32'hffffffff, 32'h4);
		chk("irq", 32'h1, {31'h0, irq});
		xfer(1'b1, REG_STATUS, 32'h4, 32'h0, 32'h0);
		xfer(1'b0, REG_STATUS, 32'h0, 32'hffffffff, 32'h0);
		@(posedge clk_i);
		chk("irq", 32'h0, {31'h0, irq});
		repeat (6) begin
			kick_it;
			repeat (3000) @(posedge clk_i);
		end
		xfer(1'b0, REG_STATUS, 32'h0, 32'hffffffff, 32'h0);
		kick_it;
		cnt(1'b0, 8000);
		rng("expiry", 1024 * TP - 24, 1024 * TP + 24, n);
		chk("fixed_reset", 32'h1, {31'h0, fx_rst_n});
		repeat (2) @(posedge clk_i);
		chk("expired", 32'h0, {31'h0, wdo_n});
		cnt(1'b1, 20000);
		rng("reset_len", 2048 * TP - 24, 2048 * TP + 24, n);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h1);
		xfer(1'b0, REG_STATUS, 32'h0, 32'hffffffff, 32'h3);
		chk("irq", 32'h1, {31'h0, irq});
		pfail <= 1'b1;
		repeat (8) @(posedge clk_i);
		chk("expired", 32'h1, {31'h0, wdo_n});
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h8);
		pfail <= 1'b0;
		batt  <= 1'b1;
		repeat (8) @(posedge clk_i);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h8);
		kick_it;
		batt <= 1'b0;
		kfl  <= 1'b1;
		repeat (8) @(posedge clk_i);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h8);
		kfl <= 1'b0;
		repeat (8) @(posedge clk_i);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h1);
		xfer(1'b1, REG_CTRL, 32'h0, 32'h0, 32'h0);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h8);
		xfer(1'b1, REG_CTRL, 32'h1, 32'h0, 32'h0);
		sel <= 1'b0;
		ext <= 1'b1;
		repeat (40) @(posedge clk_i);
		kick_it;
		cnt(1'b0, 12000);
		rng("ext_expiry", 1024 * 8 - 48, 1024 * 8 + 48, n);
		cnt(1'b1, 20000);
		rng("ext_reset_len", 2048 * 8 - 48, 2048 * 8 + 48, n);
		chk("expired", 32'h0, {31'h0, wdo_n});
		kick_it;
		repeat (40) @(posedge clk_i);
		chk("expired", 32'h1, {31'h0, wdo_n});
		sfl <= 1'b1;
		tfl <= 1'b1;
		ext <= 1'b0;
		repeat (4400) @(posedge clk_i);
		xfer(1'b0, REG_STATE, 32'h0, 32'hf, 32'h2);
		rng("float_ticks", 1024, 1200, rd[STATE_CNT_LSB +: CNT_W]);
		conclude();
	end
endmodule : swdt_bench
`default_nettype wire

// File: tb/swdt_host.sv
`timescale 1ns/1ps
`default_nettype none
module swdt_host (
	input  wire logic clk_i,   // Clock.
	input  wire logic rst_b_i, // Reset.
	input  wire logic kick_i,  // Toggle request.
	input  wire logic ext_i,   // Run external timebase.
	output var  logic kick_o,  // Kick pin.
	output var  logic tb_in_o  // Timebase pin.
);
	logic [1:0] div;

	// Each request flips the kick level, so both edge kinds are used.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			kick_o <= 1'b0;
		end else if (kick_i) begin
			kick_o <= !kick_o;
		end
	end

	// The external clock stands low when not running.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			div     <= 2'h0;
			tb_in_o <= 1'b0;
		end else if (!ext_i) begin
			div     <= 2'h0;
			tb_in_o <= 1'b0;
		end else begin
			div <= div + 2'h1;
			if (div == 2'h3) begin
				tb_in_o <= !tb_in_o;
			end
		end
	end
endmodule : swdt_host
`default_nettype wire
